// >>> src/mai_at_interp.sv
// Purpose: AT command interpreter behind the controller character port
// Assumes: Host chars arrive on wr_*, responses leave on rd_*
// Notes: Carrier pin is synchronised; one char per cycle on each port
// Notes on behaviour
// - Command mode on reset, carrier loss, escape
// - Command mode accepts lines and answers
// - Connect response sent when link established
// - Commands in, responses out, one shared location
// - Characters before the AT prefix discarded
// - A/ repeats previous line, no terminator
// - A goes off-hook in answer mode
// - H0 hangs up, H1 goes off-hook
// - D dials, passing modifiers to the dialer
// - E selects echo of command characters
// - B selects the CCITT protocol
// - I returns identification codes by argument
// - O returns to data mode after escape
// - Q0 sends responses, Q1 suppresses them
// - Sr=n writes register r with n
// - Sn? returns register n contents
// - V0 digit responses, V1 verbose responses
// - &F restores factory settings
// - Online, host chars go to the line
// - Register read gives three digits, then OK
`timescale 1ns/1ps
module mai_at_interp import mai_pkg::*; #(
	parameter logic [7:0] PRODUCT_CODE = 8'h11, // Arbitrary
	parameter logic [7:0] ROM_SUM = 8'h5a, // Arbitrary
	parameter logic [7:0] MAKER_ID = 8'h2c, // Arbitrary
	parameter logic [7:0] CONFIG_ID = 8'h03, // Arbitrary
	parameter logic [7:0] VENDOR_ID = 8'h4d // Arbitrary
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Host writes
	input wire logic wr_valid,
	input wire logic [7:0] wr_char,
	output logic wr_ready,
	// Host reads
	output logic rd_valid,
	output logic [7:0] rd_char,
	input wire logic rd_ready,
	// Line and dialer
	input wire logic carrier_pin,
	output logic line_valid,
	output logic [7:0] line_char,
	output logic dial_valid,
	output logic [7:0] dial_char,
	// Modem settings
	output logic online,
	output logic off_hook,
	output logic answer_mode,
	output logic [1:0] protocol,
	output logic echo_on,
	output logic quiet_on,
	output logic verbose_on
);
	logic rst_ff;
	logic rst_n;
	logic carrier;
	mai_state_e st, next_st;
	mai_pfx_e pfx, next_pfx;
	mai_resp_e rsel, next_rsel;
	logic [7:0] line_buf [MAI_LINE_MAX];
	logic [7:0] next_buf [MAI_LINE_MAX];
	logic [7:0] prev [MAI_LINE_MAX];
	logic [7:0] next_prev [MAI_LINE_MAX];
	logic [7:0] sreg [MAI_NUM_SREG];
	logic [7:0] next_sreg [MAI_NUM_SREG];
	logic [5:0] len, next_len, prev_len, next_prev_len, idx, next_idx;
	logic [7:0] pend, next_pend, acc, next_acc, sel, next_sel;
	logic [7:0] numv, next_numv;
	logic [3:0] ridx, next_ridx;
	logic [1:0] esc_cnt, next_esc_cnt, next_protocol;
	logic ovf, next_ovf, err, next_err, numf, next_numf;
	logic dialing, next_dialing, wait_req, next_wait_req;
	logic onl_req, next_onl_req, go_onl, next_go_onl;
	logic connected, next_connected;
	logic next_wr_ready, next_rd_valid, next_line_valid, next_dial_valid;
	logic [7:0] next_rd_char, next_line_char, next_dial_char;
	logic next_online, next_off_hook, next_answer_mode;
	logic next_echo_on, next_quiet_on, next_verbose_on;
	logic accept;
	logic [7:0] up;
	logic [7:0] c;
	logic [7:0] ch;
	logic [3:0] dv;
	logic is_dig, endl;

	// Release of the async reset is synchronised to the clock
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rst_ff <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_ff <= 1'b1;
			rst_n <= rst_ff;
		end
	end

	mai_pin_sync u_carrier (
		.clk(core_clk),
		.rst_n(rst_n),
		.pin(carrier_pin),
		.level(carrier)
	);

	function automatic logic [7:0] resp_text(input mai_resp_e rs,
		input logic verb, input logic [3:0] i, input logic [7:0] cr,
		input logic [7:0] lf);
		logic [55:0] w;
		logic [3:0] n;
		w = 56'h0;
		n = 4'h1;
		case (rs)
			RESP_OK:
			begin
				w = verb ? 56'("OK") : 56'("0");
				n = verb ? 4'h2 : 4'h1;
			end
			RESP_CONNECT:
			begin
				w = verb ? 56'("CONNECT") : 56'("1");
				n = verb ? 4'h7 : 4'h1;
			end
			default:
			begin
				w = verb ? 56'("ERROR") : 56'("4");
				n = verb ? 4'h5 : 4'h1;
			end
		endcase
		if (i < n)
			resp_text = w[{3'(n - 4'h1 - i), 3'h0} +: 8];
		else if (i == n)
			resp_text = cr;
		else if (i == n + 4'h1 && verb)
			resp_text = lf;
		else
			resp_text = 8'h00;
	endfunction : resp_text

	assign accept = wr_valid && wr_ready;
	assign up = (wr_char >= CH_LOW_A && wr_char <= CH_LOW_Z) ?
		wr_char - CASE_GAP : wr_char;
	assign c = line_buf[idx];
	assign is_dig = c >= CH_ZERO && c <= CH_NINE;
	assign dv = 4'(c - CH_ZERO);
	assign endl = idx >= len;

	always_comb
	begin
		next_st = st; next_pfx = pfx; next_rsel = rsel;
		next_buf = line_buf; next_prev = prev; next_sreg = sreg;
		next_len = len; next_prev_len = prev_len; next_idx = idx;
		next_pend = pend; next_acc = acc; next_sel = sel;
		next_numv = numv; next_ridx = ridx; next_esc_cnt = esc_cnt;
		next_ovf = ovf; next_err = err; next_numf = numf;
		next_dialing = dialing; next_wait_req = wait_req;
		next_onl_req = onl_req; next_go_onl = go_onl;
		next_connected = connected;
		next_rd_valid = rd_valid && !rd_ready;
		next_rd_char = rd_char;
		next_line_valid = 1'b0; next_line_char = line_char;
		next_dial_valid = 1'b0; next_dial_char = dial_char;
		next_off_hook = off_hook; next_answer_mode = answer_mode;
		next_protocol = protocol; next_echo_on = echo_on;
		next_quiet_on = quiet_on; next_verbose_on = verbose_on;
		ch = 8'h00;
		case (st)
			ST_CMD:
			if (accept)
			begin
				if (echo_on)
				begin
					next_rd_valid = 1'b1;
					next_rd_char = wr_char;
				end
				case (pfx)
					PFX_NONE:
						next_pfx = (up == CH_A) ? PFX_A : PFX_NONE;
					PFX_A:
					if (up == CH_T)
					begin
						next_pfx = PFX_AT;
						next_len = 6'h0;
						next_ovf = 1'b0;
					end
					else if (up == CH_SLASH)
					begin
						next_buf = prev;
						next_len = prev_len;
						next_pfx = PFX_NONE;
						next_st = ST_EXEC;
					end
					else
						next_pfx = (up == CH_A) ? PFX_A : PFX_NONE;
					default:
					if (wr_char == sreg[SREG_CR])
					begin
						next_prev = line_buf;
						next_prev_len = len;
						next_pfx = PFX_NONE;
						next_st = ST_EXEC;
					end
					else if (wr_char == CH_SPACE)
						next_pfx = PFX_AT;
					else if (len == 6'(MAI_LINE_MAX))
						next_ovf = 1'b1;
					else
					begin
						next_buf[len] = up;
						next_len = len + 6'h1;
					end
				endcase
				if (next_st == ST_EXEC)
				begin
					next_idx = 6'h0; next_pend = 8'h00;
					next_err = next_ovf && up != CH_SLASH;
					next_numf = 1'b0; next_dialing = 1'b0;
					next_wait_req = 1'b0; next_onl_req = 1'b0;
				end
			end
			ST_EXEC:
			if (dialing)
			begin
				if (endl)
				begin
					next_dialing = 1'b0;
					next_wait_req = 1'b1;
				end
				else if (c == CH_SEMI)
				begin
					next_dialing = 1'b0;
					next_idx = idx + 6'h1;
				end
				else
				begin
					next_dial_valid = 1'b1;
					next_dial_char = c;
					next_idx = idx + 6'h1;
				end
			end
			else if (pend == CH_AMP)
			begin
				if (endl || c != "F")
					next_err = 1'b1;
				else
				begin
					next_echo_on = ECHO_RST;
					next_quiet_on = QUIET_RST;
					next_verbose_on = VERBOSE_RST;
					next_protocol = PROTO_RST;
					for (int k = 0; k < MAI_NUM_SREG; k++)
						next_sreg[k] = mai_sreg_rst(k);
				end
				next_pend = 8'h00;
				next_idx = idx + 6'h1;
			end
			else if (pend != 8'h00 && !endl && is_dig)
			begin
				next_acc = 8'(acc * 8'd10 + {4'h0, dv});
				next_idx = idx + 6'h1;
			end
			else if (pend == "S" && !endl && c == CH_EQ)
			begin
				next_sel = acc;
				next_acc = 8'h00;
				next_pend = CH_EQ;
				next_idx = idx + 6'h1;
			end
			else if (pend == "S" && !endl && c == CH_QM)
			begin
				if (acc < 8'(MAI_NUM_SREG))
				begin
					next_numv = sreg[acc[4:0]];
					next_numf = 1'b1;
				end
				else
					next_err = 1'b1;
				next_pend = 8'h00;
				next_idx = idx + 6'h1;
			end
			else if (pend != 8'h00)
			begin
				next_pend = 8'h00;
				case (pend)
					"B":
					if (acc <= 8'(PROTO_MAX))
						next_protocol = acc[1:0];
					else
						next_err = 1'b1;
					"E": next_echo_on = acc[0];
					"H":
					begin
						next_off_hook = acc[0];
						if (!acc[0])
						begin
							next_answer_mode = 1'b0;
							next_connected = 1'b0;
						end
					end
					"I":
					begin
						next_numf = acc != ID_NONE;
						case (acc)
							8'h00: next_numv = PRODUCT_CODE;
							8'h01: next_numv = ROM_SUM;
							8'h03: next_numv = MAKER_ID;
							8'h04: next_numv = CONFIG_ID;
							ID_VENDOR: next_numv = VENDOR_ID;
							ID_NONE: next_numv = numv;
							default: next_err = 1'b1;
						endcase
					end
					"Q": next_quiet_on = acc[0];
					"V": next_verbose_on = acc[0];
					CH_EQ:
					if (sel < 8'(MAI_NUM_SREG))
						next_sreg[sel[4:0]] = acc;
					else
						next_err = 1'b1;
					"L", "M", "X": next_err = err;
					default: next_err = 1'b1;
				endcase
				if (acc > 8'h01 && (pend == "E" || pend == "H" ||
					pend == "Q" || pend == "V"))
					next_err = 1'b1;
			end
			else if (endl)
			begin
				next_ridx = 4'h0;
				next_go_onl = 1'b0;
				next_st = ST_RESP;
				if (err)
				begin
					next_rsel = RESP_ERROR;
					next_numf = 1'b0;
				end
				else if (wait_req)
					next_st = ST_WAIT;
				else if (onl_req)
				begin
					next_rsel = RESP_CONNECT;
					next_go_onl = 1'b1;
				end
				else
					next_rsel = RESP_OK;
				if (next_st == ST_RESP && quiet_on)
					next_st = next_go_onl ? ST_ONL : ST_CMD;
			end
			else
			begin
				next_idx = idx + 6'h1;
				next_acc = 8'h00;
				case (c)
					CH_A:
					begin
						next_off_hook = 1'b1;
						next_answer_mode = 1'b1;
						next_wait_req = 1'b1;
					end
					"D":
					begin
						next_off_hook = 1'b1;
						next_answer_mode = 1'b0;
						next_dialing = 1'b1;
					end
					"O":
					if (connected)
						next_onl_req = 1'b1;
					else
						next_err = 1'b1;
					"B", "E", "H", "I", "L", "M", "Q", "V", "X", "S", CH_AMP:
						next_pend = c;
					default: next_err = 1'b1;
				endcase
			end
			ST_RESP:
			if (!rd_valid || rd_ready)
			begin
				if (numf)
				begin
					case (ridx)
						4'h0: ch = CH_ZERO + numv / 8'd100;
						4'h1: ch = CH_ZERO + (numv / 8'd10) % 8'd10;
						4'h2: ch = CH_ZERO + numv % 8'd10;
						4'h3: ch = sreg[SREG_CR];
						default: ch = sreg[SREG_LF];
					endcase
					next_rd_valid = 1'b1;
					next_rd_char = ch;
					next_numf = ridx != 4'h4;
					next_ridx = (ridx == 4'h4) ? 4'h0 : ridx + 4'h1;
				end
				else
				begin
					ch = resp_text(rsel, verbose_on, ridx,
						sreg[SREG_CR], sreg[SREG_LF]);
					if (ch == 8'h00)
						next_st = go_onl ? ST_ONL : ST_CMD;
					else
					begin
						next_rd_valid = 1'b1;
						next_rd_char = ch;
						next_ridx = ridx + 4'h1;
					end
				end
			end
			ST_WAIT:
			if (carrier)
			begin
				next_connected = 1'b1;
				next_rsel = RESP_CONNECT;
				next_go_onl = 1'b1;
				next_ridx = 4'h0;
				next_st = quiet_on ? ST_ONL : ST_RESP;
			end
			else if (accept)
			begin
				// Any key aborts a call that never connects
				next_off_hook = 1'b0;
				next_answer_mode = 1'b0;
				next_rsel = RESP_ERROR;
				next_go_onl = 1'b0;
				next_ridx = 4'h0;
				next_st = quiet_on ? ST_CMD : ST_RESP;
			end
			ST_ONL:
			if (accept)
			begin
				next_line_valid = 1'b1;
				next_line_char = wr_char;
				next_esc_cnt = (wr_char == sreg[SREG_ESC]) ?
					esc_cnt + 2'h1 : 2'h0;
				if (next_esc_cnt == MAI_ESC_COUNT)
				begin
					next_esc_cnt = 2'h0;
					next_rsel = RESP_OK;
					next_go_onl = 1'b0;
					next_ridx = 4'h0;
					next_numf = 1'b0;
					next_st = quiet_on ? ST_CMD : ST_RESP;
				end
			end
			default: next_st = ST_CMD;
		endcase
		if (connected && !carrier)
		begin
			// A drop during the connect message must not strand the call
			next_connected = 1'b0;
			next_go_onl = 1'b0;
			if (st == ST_ONL || go_onl)
			begin
				next_off_hook = 1'b0;
				next_answer_mode = 1'b0;
			end
			if (st == ST_ONL || next_st == ST_ONL)
				next_st = ST_CMD;
		end
		next_online = next_st == ST_ONL;
		next_wr_ready = (next_st == ST_CMD || next_st == ST_ONL ||
			next_st == ST_WAIT) && !next_rd_valid;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st <= ST_CMD; pfx <= PFX_NONE; rsel <= RESP_OK;
			for (int k = 0; k < MAI_LINE_MAX; k++)
			begin
				line_buf[k] <= 8'h00;
				prev[k] <= 8'h00;
			end
			for (int k = 0; k < MAI_NUM_SREG; k++)
				sreg[k] <= mai_sreg_rst(k);
			len <= 6'h0; prev_len <= 6'h0; idx <= 6'h0;
			pend <= 8'h00; acc <= 8'h00; sel <= 8'h00; numv <= 8'h00;
			ridx <= 4'h0; esc_cnt <= 2'h0; ovf <= 1'b0; err <= 1'b0;
			numf <= 1'b0; dialing <= 1'b0; wait_req <= 1'b0;
			onl_req <= 1'b0; go_onl <= 1'b0; connected <= 1'b0;
			wr_ready <= 1'b0; rd_valid <= 1'b0; rd_char <= 8'h00;
			line_valid <= 1'b0; line_char <= 8'h00;
			dial_valid <= 1'b0; dial_char <= 8'h00;
			online <= 1'b0; off_hook <= 1'b0; answer_mode <= 1'b0;
			protocol <= PROTO_RST; echo_on <= ECHO_RST;
			quiet_on <= QUIET_RST; verbose_on <= VERBOSE_RST;
		end
		else
		begin
			st <= next_st; pfx <= next_pfx; rsel <= next_rsel;
			line_buf <= next_buf; prev <= next_prev; sreg <= next_sreg;
			len <= next_len; prev_len <= next_prev_len; idx <= next_idx;
			pend <= next_pend; acc <= next_acc; sel <= next_sel;
			numv <= next_numv; ridx <= next_ridx; esc_cnt <= next_esc_cnt;
			ovf <= next_ovf; err <= next_err; numf <= next_numf;
			dialing <= next_dialing; wait_req <= next_wait_req;
			onl_req <= next_onl_req; go_onl <= next_go_onl;
			connected <= next_connected; wr_ready <= next_wr_ready;
			rd_valid <= next_rd_valid; rd_char <= next_rd_char;
			line_valid <= next_line_valid; line_char <= next_line_char;
			dial_valid <= next_dial_valid; dial_char <= next_dial_char;
			online <= next_online; off_hook <= next_off_hook;
			answer_mode <= next_answer_mode; protocol <= next_protocol;
			echo_on <= next_echo_on; quiet_on <= next_quiet_on;
			verbose_on <= next_verbose_on;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_escape_enter: assert property ((st == ST_ONL) && accept && carrier
		&& wr_char == sreg[SREG_ESC] && esc_cnt == 2'h2 |=> !online)
		else $error("escape did not leave data mode");
	chk_carrier_loss: assert property ((st == ST_ONL) && connected
		&& !carrier |=> st == ST_CMD && !off_hook)
		else $error("carrier loss did not return to command mode");
	chk_connect_resp: assert property ((st == ST_WAIT) && carrier
		&& !quiet_on |=> st == ST_RESP && rsel == RESP_CONNECT)
		else $error("no connect response");
	chk_ready_share: assert property (wr_ready |-> !rd_valid)
		else $error("write taken while a response waits");
	chk_len_limit: assert property (len <= 6'(MAI_LINE_MAX))
		else $error("line buffer over its limit");
	chk_prefix_drop: assert property ((st == ST_CMD) && accept
		&& pfx == PFX_NONE && up != CH_A |=> pfx == PFX_NONE)
		else $error("char before prefix not discarded");
	chk_repeat_line: assert property ((st == ST_CMD) && accept
		&& pfx == PFX_A && up == CH_SLASH
		|=> st == ST_EXEC && len == $past(prev_len))
		else $error("repeat did not reload previous line");
	chk_quiet_hold: assert property ((st == ST_EXEC) && quiet_on
		|=> st != ST_RESP)
		else $error("response sent while quiet");
	chk_online_tx: assert property ((st == ST_ONL) && accept
		|=> line_valid && line_char == $past(wr_char))
		else $error("data char not sent to line");
	chk_ovf_error: assert property ((st == ST_CMD) && accept
		&& pfx == PFX_AT && wr_char == sreg[SREG_CR] && ovf
		|=> err ##1 (!numf)[*2])
		else $error("overlong line not flagged");

	cov_online: cover property ((st == ST_WAIT) ##1 (st == ST_ONL)
		or (st == ST_WAIT) ##1 (st == ST_RESP) ##[1:40] (st == ST_ONL));
	cov_sreg_read: cover property ((st == ST_RESP) && numf && rd_valid);
	cov_escape: cover property ((st == ST_ONL) ##1 (st == ST_RESP));
endmodule : mai_at_interp

// >>> src/mai_pkg.sv
// Purpose: Shared constants and types for the AT command interpreter
// Assumes: 8-bit characters, single core clock domain
// Notes: Shared character codes and S-register defaults live here; command letters other than A are literals in the interpreter
package mai_pkg;
	localparam int MAI_LINE_MAX = 40;
	localparam int MAI_NUM_SREG = 28;
	localparam logic [1:0] MAI_ESC_COUNT = 2'h3;
	localparam logic [7:0] CH_A = 8'h41;
	localparam logic [7:0] CH_T = 8'h54;
	localparam logic [7:0] CH_SLASH = 8'h2f;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [7:0] CH_EQ = 8'h3d;
	localparam logic [7:0] CH_QM = 8'h3f;
	localparam logic [7:0] CH_AMP = 8'h26;
	localparam logic [7:0] CH_SEMI = 8'h3b;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_LOW_A = 8'h61;
	localparam logic [7:0] CH_LOW_Z = 8'h7a;
	localparam logic [7:0] CASE_GAP = 8'h20;
	localparam int SREG_ESC = 2;
	localparam int SREG_CR = 3;
	localparam int SREG_LF = 4;
	localparam int SREG_BS = 5;
	localparam logic [7:0] SREG_ESC_RST = 8'h2b;
	localparam logic [7:0] SREG_CR_RST = 8'h0d;
	localparam logic [7:0] SREG_LF_RST = 8'h0a;
	localparam logic [7:0] SREG_BS_RST = 8'h08;
	localparam logic ECHO_RST = 1'b1;
	localparam logic QUIET_RST = 1'b0;
	localparam logic VERBOSE_RST = 1'b1;
	localparam logic [1:0] PROTO_RST = 2'h0;
	localparam logic [1:0] PROTO_MAX = 2'h2;
	localparam logic [7:0] ID_NONE = 8'h02;
	localparam logic [7:0] ID_VENDOR = 8'h21;

	typedef enum logic [4:0] {
		ST_CMD = 5'h01,
		ST_EXEC = 5'h02,
		ST_RESP = 5'h04,
		ST_WAIT = 5'h08,
		ST_ONL = 5'h10
	} mai_state_e;

	typedef enum logic [1:0] {
		PFX_NONE = 2'h0,
		PFX_A = 2'h1,
		PFX_AT = 2'h2
	} mai_pfx_e;

	typedef enum logic [1:0] {
		RESP_OK = 2'h0,
		RESP_CONNECT = 2'h1,
		RESP_ERROR = 2'h2
	} mai_resp_e;

	function automatic logic [7:0] mai_sreg_rst(input int i);
		case (i)
			SREG_ESC: mai_sreg_rst = SREG_ESC_RST;
			SREG_CR: mai_sreg_rst = SREG_CR_RST;
			SREG_LF: mai_sreg_rst = SREG_LF_RST;
			SREG_BS: mai_sreg_rst = SREG_BS_RST;
			default: mai_sreg_rst = 8'h00;
		endcase
	endfunction : mai_sreg_rst
endpackage : mai_pkg

// >>> src/mai_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pin is asynchronous to core_clk
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
module mai_pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pin and filtered level
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	always_comb
	begin
		next_level = (s2 == s3) ? s3 : level;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end
endmodule : mai_pin_sync

// >>> verification/mai_remote.sv
// Purpose: Remote modem stand-in on the telephone side
// Assumes: Carrier follows link_up after a settable delay
// Notes: Records what the line port sends
`timescale 1ns/1ps
module mai_remote #(
	parameter int DELAY_NS = 17
) (
	// Clock
	input wire logic core_clk,
	// Bench control
	input wire logic link_up,
	// Line side
	output logic carrier_pin,
	input wire logic line_valid,
	input wire logic [7:0] line_char,
	// Capture
	output logic [7:0] rx_last,
	output int rx_count
);
	initial
	begin
		carrier_pin = 1'b0;
		rx_last = 8'h00;
		rx_count = 0;
	end
	// Off the clock edge, as a real pin would move
	always @(link_up)
		carrier_pin <= #(DELAY_NS) link_up;
	always @(posedge core_clk)
		if (line_valid === 1'b1)
		begin
			rx_last <= line_char;
			rx_count <= rx_count + 1;
		end
endmodule : mai_remote

// >>> verification/mai_at_interp_test.sv
// Purpose: Self-checking bench for the AT command interpreter
// Assumes: Host side sends one char per handshake
// Notes: Echo and responses are compared in order through a queue
`timescale 1ns/1ps
module mai_at_interp_test;
	localparam logic [7:0] VEND = 8'h9c; // Arbitrary
	localparam logic [7:0] PROD = 8'h07; // Arbitrary
	localparam logic [7:0] ROMS = 8'hb4; // Arbitrary
	localparam logic [7:0] MAKER = 8'h3e; // Arbitrary
	localparam logic [7:0] CONF = 8'h61; // Arbitrary
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic wr_valid = 1'b0;
	logic [7:0] wr_char = 8'h00;
	logic rd_ready = 1'b0;
	logic link_up = 1'b0;
	logic wr_ready, rd_valid, line_valid, dial_valid, carrier_pin;
	logic [7:0] rd_char, line_char, dial_char, rx_last;
	logic online, off_hook, answer_mode, echo_on, quiet_on, verbose_on;
	logic [1:0] protocol;
	int rx_count;
	int errors = 0;
	int tests_run = 0;
	int n;
	logic [7:0] exp_q[$];
	logic [7:0] dial_q[$];
	string dial_exp = "P9W@!";

	always #2.5 core_clk = ~core_clk;

	mai_at_interp #(.PRODUCT_CODE(PROD), .ROM_SUM(ROMS), .MAKER_ID(MAKER),
		.CONFIG_ID(CONF), .VENDOR_ID(VEND)) dut (
		.core_clk(core_clk), .arst_n(arst_n),
		.wr_valid(wr_valid), .wr_char(wr_char), .wr_ready(wr_ready),
		.rd_valid(rd_valid), .rd_char(rd_char), .rd_ready(rd_ready),
		.carrier_pin(carrier_pin), .line_valid(line_valid),
		.line_char(line_char), .dial_valid(dial_valid),
		.dial_char(dial_char), .online(online), .off_hook(off_hook),
		.answer_mode(answer_mode), .protocol(protocol),
		.echo_on(echo_on), .quiet_on(quiet_on), .verbose_on(verbose_on)
	);

	mai_remote far (
		.core_clk(core_clk), .link_up(link_up),
		.carrier_pin(carrier_pin), .line_valid(line_valid),
		.line_char(line_char), .rx_last(rx_last), .rx_count(rx_count)
	);

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic summarize;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// Reader stalls at random so held responses get exercised
	always @(posedge core_clk)
	begin
		rd_ready <= ($urandom % 4) != 0;
		if (dial_valid === 1'b1)
			dial_q.push_back(dial_char);
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("rd_char extra", 8'h00, rd_char);
			else
				check("rd_char", exp_q.pop_front(), rd_char);
		end
	end

	task automatic send(input string s);
		int k;
		for (int i = 0; i < s.len(); i++)
		begin
			@(posedge core_clk);
			wr_valid <= 1'b1;
			wr_char <= s[i];
			k = 0;
			do
			begin
				@(posedge core_clk);
				k++;
			end
			while (wr_ready !== 1'b1 && k < 500);
			wr_valid <= 1'b0;
			if (k >= 500)
				check("wr_ready", 8'h01, 8'(wr_ready));
		end
	endtask : send

	task automatic run(input string name, input string s, input string r);
		int k;
		for (int i = 0; i < r.len(); i++)
			exp_q.push_back(r[i]);
		send(s);
		k = 0;
		while (exp_q.size() != 0 && k < 3000)
		begin
			@(posedge core_clk);
			k++;
		end
		repeat (30) @(posedge core_clk);
		check({name, " left"}, 8'h00, 8'(exp_q.size()));
		$display("test %s done", name);
	endtask : run

	initial
	begin
		#(80000 * 5);
		check("watchdog", 8'h00, 8'h01);
		summarize();
	end

	initial
	begin
		void'($urandom(32'hc53b));
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		run("echo", "ATE0\r", "ATE0\rOK\r\n");
		check("echo_on", 8'h00, 8'(echo_on));
		run("swr", "ATS7=200\r", "OK\r\n");
		run("srd", "AT S7?\r", "200\r\nOK\r\n");
		n = $urandom % 256;
		run("srand", $sformatf("ATS27=%0d\r", n), "OK\r\n");
		run("srd2", "ATS27?\r", $sformatf("%03d\r\nOK\r\n", n));
		run("id0", "ATI0\r", $sformatf("%03d\r\nOK\r\n", PROD));
		run("id2", "ATI2\r", "OK\r\n");
		run("id1", "ATI1\r", $sformatf("%03d\r\nOK\r\n", ROMS));
		run("id3", "ATI3\r", $sformatf("%03d\r\nOK\r\n", MAKER));
		run("id4", "ATI4\r", $sformatf("%03d\r\nOK\r\n", CONF));
		run("ignored", "ATL1M0X4\r", "OK\r\n");
		run("id33", "xyATI33\r", $sformatf("%03d\r\nOK\r\n", VEND));
		run("again", "A/", $sformatf("%03d\r\nOK\r\n", VEND));
		run("badreg", "ATS28?\r", "ERROR\r\n");
		run("long", {"AT", {45{"L"}}, "\r"}, "ERROR\r\n");
		run("digit", "ATV0\r", "0\r");
		check("verbose_on", 8'h00, 8'(verbose_on));
		run("verb", "ATV1\r", "OK\r\n");
		run("quiet", "ATQ1\r", "");
		check("quiet_on", 8'h01, 8'(quiet_on));
		run("loud", "ATQ0\r", "OK\r\n");
		run("proto", "ATB2\r", "OK\r\n");
		check("protocol", 8'h02, 8'(protocol));
		run("proto_bad", "ATB3\r", "ERROR\r\n");
		run("hook1", "ATH1\r", "OK\r\n");
		check("off_hook", 8'h01, 8'(off_hook));
		run("hook0", "ATH0\r", "OK\r\n");
		check("off_hook", 8'h00, 8'(off_hook));
		run("dial", "atdp9w@!\r", "");
		check("dial count", 8'(dial_exp.len()), 8'(dial_q.size()));
		for (int i = 0; i < dial_q.size() && i < dial_exp.len(); i++)
			check("dial_char", dial_exp[i], dial_q[i]);
		run("abort", "x", "ERROR\r\n");
		run("dial_semi", "ATDT5;\r", "OK\r\n");
		check("dial count", 8'h07, 8'(dial_q.size()));
		check("dial_char", "5", dial_q[6]);
		check("off_hook", 8'h01, 8'(off_hook));
		run("answer", "ATA\r", "");
		check("answer_mode", 8'h01, 8'(answer_mode));
		link_up <= 1'b1;
		run("connect", "", "CONNECT\r\n");
		check("online", 8'h01, 8'(online));
		run("escape", "h+++", "OK\r\n");
		check("line count", 8'h04, 8'(rx_count));
		check("line char", 8'h2b, rx_last);
		check("online", 8'h00, 8'(online));
		run("resume", "ATO\r", "CONNECT\r\n");
		check("online", 8'h01, 8'(online));
		link_up <= 1'b0;
		repeat (40) @(posedge core_clk);
		check("online", 8'h00, 8'(online));
		check("off_hook", 8'h00, 8'(off_hook));
		check("answer_mode", 8'h00, 8'(answer_mode));
		run("factory", "AT&F\r", "OK\r\n");
		check("echo_on", 8'h01, 8'(echo_on));
		check("protocol", 8'h00, 8'(protocol));
		summarize();
	end
endmodule : mai_at_interp_test
